// ===== bench/pcp_periph_model.sv
// peripheral circuit and feed shifter behind the port
`timescale 1ns/1ps
module pcp_periph_model (
  input wire clk_sys_i,
  input wire frame_i,
  input wire feed_bit_strobe_i,
  input wire [1:0] port_address_lines_o,
  input wire [2:0] port_data_lines_o,
  input wire port_data_lines_oe_n_o,
  input wire port_read_strobe_o,
  input wire port_write_strobe_o,
  input wire [7:0] feed_value_i,
  output logic [2:0] port_data_lines_i,
  output logic power_status_secondary_or_feed_in_i
);
  logic [2:0] mem [0:3];
  logic [7:0] shift;
  always @(posedge clk_sys_i) begin
    if (port_write_strobe_o && !port_data_lines_oe_n_o)
      mem[port_address_lines_o] <= port_data_lines_o;
    if (frame_i)
      shift <= feed_value_i;
    else if (feed_bit_strobe_i)
      shift <= {shift[6:0], ~shift[7]};
  end
  // lines show the inverse outside a read so a stale sample cannot match
  assign port_data_lines_i = port_read_strobe_o ? mem[port_address_lines_o] :
    ~mem[port_address_lines_o];
  assign power_status_secondary_or_feed_in_i = shift[7];
endmodule

// ===== bench/pcp_port_chk.sv
// pin-level assertions for the power controller port
`timescale 1ns/1ps
module pcp_port_chk (
  input wire clk_sys_i,
  input wire rst_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire port_interrupt_i,
  input wire power_status_primary_i,
  input wire power_status_secondary_or_feed_in_i,
  input wire [1:0] port_address_lines_o,
  input wire port_data_lines_oe_n_o,
  input wire port_read_strobe_o,
  input wire port_write_strobe_o,
  input wire [3:0] ci_code_o,
  input wire primary_status_overhead_bit_o,
  input wire secondary_status_overhead_bit_o,
  input wire test_state_o,
  input wire link_drop_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  chk_strobe_excl: assert property (!(port_read_strobe_o && port_write_strobe_o))
    else $error("strobes overlap");
  chk_wr_drive: assert property (port_write_strobe_o |-> !port_data_lines_oe_n_o)
    else $error("write strobe without data");
  chk_wr_release: assert property ($fell(port_write_strobe_o) |-> port_data_lines_oe_n_o)
    else $error("data held after write");
  chk_rd_listen: assert property (port_read_strobe_o |-> port_data_lines_oe_n_o)
    else $error("driving during read");
  chk_addr_cause: assert property ($changed(port_address_lines_o) |->
    $past(reg_wr_i) && $past(reg_addr_i) == 8'h04)
    else $error("address moved without command");
  chk_int_code: assert property ($changed(port_interrupt_i) && !power_status_primary_i |->
    ##[2:5] ci_code_o == 4'h6)
    else $error("no interrupt code");
  chk_drop_test: assert property (link_drop_o |-> ##[0:1] test_state_o)
    else $error("link drop outside test state");
  chk_ov_follow: assert property ($rose(primary_status_overhead_bit_o) |->
    $past(power_status_primary_i, 2) || $past(power_status_primary_i, 3))
    else $error("overhead bit without status");
  chk_ov2_follow: assert property ($rose(secondary_status_overhead_bit_o) |->
    $past(power_status_secondary_or_feed_in_i, 3))
    else $error("secondary overhead bit without status");
endmodule
bind pcp_power_controller_port pcp_port_chk u_chk (.clk_sys_i, .rst_i, .reg_wr_i, .reg_addr_i,
  .port_interrupt_i, .power_status_primary_i, .port_address_lines_o, .port_data_lines_oe_n_o,
  .port_read_strobe_o, .port_write_strobe_o, .ci_code_o, .primary_status_overhead_bit_o,
  .secondary_status_overhead_bit_o, .power_status_secondary_or_feed_in_i, .test_state_o,
  .link_drop_o);

// ===== bench/power_controller_port_tb_top.sv
// testbench for the power controller port
`timescale 1ns/1ps
module power_controller_port_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, frame_i = 1'b0, feed_bit_strobe_i = 1'b0;
  logic close_loop_cmd_i = 1'b0, return_normal_cmd_i = 1'b0;
  logic port_interrupt_i = 1'b0, power_status_primary_i = 1'b0;
  logic [2:0] port_data_lines_i, port_data_lines_o;
  logic [31:0] reg_rdata_o;
  logic [1:0] port_address_lines_o;
  logic [3:0] ci_code_o;
  logic power_status_secondary_or_feed_in_i, port_data_lines_oe_n_o, port_read_strobe_o;
  logic port_write_strobe_o, power_disable_out_o, primary_status_overhead_bit_o;
  logic test_state_o, link_drop_o, secondary_status_overhead_bit_o;
  logic [5:0] tick = 6'h00;
  integer mismatches = 0;
  integer cmp_count = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  pcp_power_controller_port dut (.clk_sys_i, .rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .frame_i, .feed_bit_strobe_i, .close_loop_cmd_i,
    .return_normal_cmd_i, .port_data_lines_i, .port_data_lines_o, .port_data_lines_oe_n_o,
    .port_address_lines_o, .port_read_strobe_o, .port_write_strobe_o, .port_interrupt_i,
    .power_status_primary_i, .power_status_secondary_or_feed_in_i, .power_disable_out_o,
    .ci_code_o, .primary_status_overhead_bit_o, .secondary_status_overhead_bit_o,
    .test_state_o, .link_drop_o);
  pcp_periph_model partner (.clk_sys_i, .frame_i, .feed_bit_strobe_i, .port_address_lines_o,
    .port_data_lines_o, .port_data_lines_oe_n_o, .port_read_strobe_o, .port_write_strobe_o,
    .feed_value_i(8'hA5), .port_data_lines_i, .power_status_secondary_or_feed_in_i);
  // frame every 40 cycles, eight feed bit slots after it
  always @(posedge clk_sys_i) begin
    tick <= (tick == 6'h27) ? 6'h00 : tick + 6'h01;
    frame_i <= (tick == 6'h27);
    feed_bit_strobe_i <= (tick[1:0] == 2'h3) && (tick < 6'h20);
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input [31:0] g, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, output [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata_o;
  endtask
  task automatic poll(input [7:0] a, input integer b, input v, output [31:0] d);
    integer k;
    for (k = 0; k < 100; k = k + 1) begin
      rd(a, d);
      if (d[b] === v)
        k = 200;
    end
    if (k == 100) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0t poll timeout", $time);
      final_report;
    end
  endtask
  task automatic do_reset;
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask
  task automatic pulse(input c, input r);
    @(posedge clk_sys_i);
    close_loop_cmd_i <= c;
    return_normal_cmd_i <= r;
    @(posedge clk_sys_i);
    close_loop_cmd_i <= 1'b0;
    return_normal_cmd_i <= 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask
  task automatic t_port;
    logic [31:0] d;
    wr(8'h04, 32'h0000_807C);
    @(negedge clk_sys_i);
    chk({port_address_lines_o, port_data_lines_o, port_data_lines_oe_n_o}, 6'h0E);
    poll(8'h04, 0, 1'b0, d);
    chk(port_data_lines_oe_n_o, 1'b1);
    wr(8'h04, 32'h0000_8040);
    poll(8'h08, 24, 1'b1, d);
    chk(d, 32'h0180_1C00);
    rd(8'h08, d);
    chk(d[24], 1'b0);
    wr(8'h04, 32'h0000_8062);
    poll(8'h04, 0, 1'b0, d);
    wr(8'h04, 32'h0000_4041);
    repeat (30) @(negedge clk_sys_i);
    chk(port_address_lines_o, 2'h2);
    $display("port access test done");
  endtask
  task automatic t_feed;
    logic [31:0] d;
    repeat (90) @(negedge clk_sys_i);
    rd(8'h10, d);
    chk(d[15:8], 8'hA5);
    wr(8'h04, 32'h0000_8080);
    poll(8'h08, 24, 1'b1, d);
    chk(d, 32'h0180_A0A5);
    $display("feed test done");
  endtask
  task automatic t_int(input v, input [31:0] ctrl);
    integer n, k;
    n = 0;
    wr(8'h00, ctrl);
    @(posedge clk_sys_i) port_interrupt_i <= v;
    for (k = 0; k < 300; k = k + 1) begin
      @(negedge clk_sys_i);
      if (ci_code_o === 4'h6 && frame_i === 1'b1)
        n = n + 1;
    end
    chk(n, 4);
    chk(ci_code_o, 4'hF);
    $display("interrupt test done");
  endtask
  task automatic t_nt;
    wr(8'h00, 32'h0000_0001);
    pulse(1'b1, 1'b0);
    chk(power_disable_out_o, 1'b0);
    wr(8'h00, 32'h0000_0003);
    @(posedge clk_sys_i) power_status_primary_i <= 1'b1;
    pulse(1'b1, 1'b0);
    chk({power_disable_out_o, primary_status_overhead_bit_o}, 2'h3);
    @(posedge clk_sys_i) power_status_primary_i <= 1'b0;
    pulse(1'b0, 1'b1);
    chk({power_disable_out_o, primary_status_overhead_bit_o}, 2'h0);
    $display("network mode test done");
  endtask
  task automatic t_lt;
    integer k, n;
    n = 0;
    wr(8'h00, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0001);
    repeat (4) @(negedge clk_sys_i);
    chk(power_disable_out_o, 1'b0);
    wr(8'h0C, 32'h0000_0003);
    repeat (4) @(negedge clk_sys_i);
    chk({power_disable_out_o, test_state_o}, 2'h3);
    wr(8'h0C, 32'h0000_0001);
    repeat (4) @(negedge clk_sys_i);
    chk({power_disable_out_o, test_state_o}, 2'h3);
    do_reset;
    @(posedge clk_sys_i) power_status_primary_i <= 1'b1;
    for (k = 0; k < 20; k = k + 1) begin
      @(negedge clk_sys_i);
      n = n + (link_drop_o === 1'b1);
    end
    chk({n[1:0], ci_code_o, test_state_o}, 7'h27);
    chk(secondary_status_overhead_bit_o, 1'b0);
    @(posedge clk_sys_i) power_status_primary_i <= 1'b0;
    $display("line mode test done");
  endtask
  initial begin
    do_reset;
    @(negedge clk_sys_i);
    chk({power_disable_out_o, port_data_lines_oe_n_o, ci_code_o}, 6'h1F);
    t_port;
    t_feed;
    t_int(1'b1, 32'h0000_0000);
    t_int(1'b0, 32'h0000_0001);
    t_nt;
    t_lt;
    final_report;
  end
endmodule

// ===== hdl/pcp_power_controller_port.v
// power controller port: monitor commands to peripheral port and power pins
//
// Overview of operation
// - port has three data lines, two address lines, read/write strobes, interrupt input.
// - address lines hold their last written value between accesses.
// - only local monitor class messages to this port start a port access.
// - write drives message address and data; address stays latched, data released.
// - read latches address onto lines and samples the three data lines.
// - every read sends a port answer message with the sampled bits; a read ending by the next frame replaces an unsent answer.
// - each interrupt input edge sends code 0110 for four bus frames; while line mode power-off is high those frames carry 0011 instead.
// - peripheral port works the same in both termination modes.
// - network mode copies power status inputs into overhead bits; high means working.
// - network auto mode close-loop command sets the disable output high.
// - network mode return-to-normal command or a hardware reset clears disable output.
// - line mode power-off input high sends code 0011 and forces test state.
// - power-off forced test state drops any existing line connection.
// - latest feed value is kept and offered through a local monitor message.
// - line mode line-disable code 0011 sets the disable output high.
// - soft reset command leaves the disable output unchanged.
// - while line mode disable output is high the device stays in test state.
// - line mode uses serial bus codes, network mode uses overhead and operations bits.
// - a feed request is answered in the next available bus frame.
// - primary status maps to overhead bit two, secondary to bit three.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "pcp_defs.vh"
module pcp_power_controller_port #(
  parameter CLK_MHZ = 125
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  input wire frame_i,
  input wire feed_bit_strobe_i,
  input wire close_loop_cmd_i,
  input wire return_normal_cmd_i,
  input wire [2:0] port_data_lines_i,
  output reg [2:0] port_data_lines_o,
  output reg port_data_lines_oe_n_o,
  output reg [1:0] port_address_lines_o,
  output reg port_read_strobe_o,
  output reg port_write_strobe_o,
  input wire port_interrupt_i,
  input wire power_status_primary_i,
  input wire power_status_secondary_or_feed_in_i,
  output reg power_disable_out_o,
  output reg [3:0] ci_code_o,
  output reg primary_status_overhead_bit_o,
  output reg secondary_status_overhead_bit_o,
  output reg test_state_o,
  output reg link_drop_o
);
  // setup and strobe lengths round up, so a pulse is never shorter than intended
  localparam STROBE_CYC = (`PCP_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam [7:0] STROBE_CNT = STROBE_CYC[7:0];
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WR_SETUP = 3'h1;
  localparam [2:0] ST_WR_STROBE = 3'h2;
  localparam [2:0] ST_RD_SETUP = 3'h3;
  localparam [2:0] ST_RD_STROBE = 3'h4;

  // address compare shared by the write and answer-read decodes; the read data mux uses a case
  function sel;
    input [7:0] a;
    input [7:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  // two-flop synchronisers for pins
  // the edge detector reads only the second stage and resets to the idle pin level
  reg [2:0] data_s1_reg;
  reg [2:0] data_s2_reg;
  reg [2:0] pin_s1_reg;
  reg [2:0] pin_s2_reg;
  reg int_prev_reg;
  reg [2:0] state_reg;
  reg [7:0] cnt_reg;
  reg nt_mode_reg;
  reg auto_mode_reg;
  reg [23:0] ans_msg_reg;
  reg ans_pend_reg;
  reg ans_valid_reg;
  reg [2:0] int_frames_reg;
  reg [7:0] feed_shift_reg;
  reg [3:0] feed_cnt_reg;
  reg [7:0] feed_value_reg;
  reg feed_req_reg;
  reg power_off_prev_reg;

  wire int_s = pin_s2_reg[0];
  wire prim_s = pin_s2_reg[1];
  wire sec_s = pin_s2_reg[2];
  wire lt_power_off = ~nt_mode_reg & prim_s;
  // monitor write: class in bits 15:8, command byte in bits 7:0
  wire wr_tx = reg_wr_i & sel(reg_addr_i, `PCP_ADDR_MON_TX);
  wire wr_ci = reg_wr_i & sel(reg_addr_i, `PCP_ADDR_CI);
  wire rd_rx = reg_rd_i & sel(reg_addr_i, `PCP_ADDR_MON_RX);
  wire [7:0] tx_class = reg_wdata_i[15:8];
  wire [7:0] tx_cmd = reg_wdata_i[7:0];
  wire [2:0] tx_type = tx_cmd[`PCP_TYPE_MSB:`PCP_TYPE_LSB];
  wire tx_local = wr_tx & (tx_class == `PCP_LOCAL_MONITOR_CLASS);
  wire start_wr = tx_local & (tx_type == `PCP_TYPE_WRITE) & (state_reg == ST_IDLE);
  wire start_rd = tx_local & (tx_type == `PCP_TYPE_READ) & (state_reg == ST_IDLE);
  wire feed_rq = tx_local & (tx_type == `PCP_TYPE_FEED_REQ);
  // the read ends on the last strobe cycle, when the synced data has settled
  wire rd_done = (state_reg == ST_RD_STROBE) & (cnt_reg == 8'h00);
  wire [3:0] ci_in = reg_wdata_i[3:0];

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      data_s1_reg <= 3'h0;
      data_s2_reg <= 3'h0;
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
      int_prev_reg <= 1'b0;
    end else if (ce_i) begin
      data_s1_reg <= port_data_lines_i;
      data_s2_reg <= data_s1_reg;
      pin_s1_reg <= {power_status_secondary_or_feed_in_i, power_status_primary_i,
                     port_interrupt_i};
      pin_s2_reg <= pin_s1_reg;
      int_prev_reg <= int_s;
    end
  end

  // peripheral port sequencer, same in both modes
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      port_address_lines_o <= 2'h0;
      port_data_lines_o <= 3'h0;
      port_data_lines_oe_n_o <= 1'b1;
      port_read_strobe_o <= 1'b0;
      port_write_strobe_o <= 1'b0;
    end else if (ce_i) begin
      case (state_reg)
        ST_IDLE: begin
          // the address stays on the pins after an access, free for general outputs
          if (start_wr) begin
            port_address_lines_o <= tx_cmd[`PCP_ADDR_MSB:`PCP_ADDR_LSB];
            port_data_lines_o <= tx_cmd[`PCP_DATA_MSB:`PCP_DATA_LSB];
            port_data_lines_oe_n_o <= 1'b0;
            cnt_reg <= STROBE_CNT;
            state_reg <= ST_WR_SETUP;
          end else if (start_rd) begin
            port_address_lines_o <= tx_cmd[`PCP_ADDR_MSB:`PCP_ADDR_LSB];
            cnt_reg <= STROBE_CNT;
            state_reg <= ST_RD_SETUP;
          end
        end
        ST_WR_SETUP: begin
          if (cnt_reg == 8'h00) begin
            port_write_strobe_o <= 1'b1;
            cnt_reg <= STROBE_CNT;
            state_reg <= ST_WR_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_WR_STROBE: begin
          if (cnt_reg == 8'h00) begin
            port_write_strobe_o <= 1'b0;
            port_data_lines_oe_n_o <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_RD_SETUP: begin
          if (cnt_reg == 8'h00) begin
            port_read_strobe_o <= 1'b1;
            cnt_reg <= STROBE_CNT;
            state_reg <= ST_RD_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_RD_STROBE: begin
          if (cnt_reg == 8'h00) begin
            port_read_strobe_o <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        // stray state codes return to idle with the port released
        default: begin
          state_reg <= ST_IDLE;
          port_read_strobe_o <= 1'b0;
          port_write_strobe_o <= 1'b0;
          port_data_lines_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // answer messages, handed out at the next frame
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ans_msg_reg <= 24'h00_0000;
      ans_pend_reg <= 1'b0;
      ans_valid_reg <= 1'b0;
      feed_req_reg <= 1'b0;
    end else if (ce_i) begin
      // a new read answer takes priority over handing out the pending one
      if (rd_done) begin
        ans_msg_reg <= {`PCP_LOCAL_MONITOR_CLASS, `PCP_TYPE_ANSWER, data_s2_reg,
                        port_address_lines_o, 8'h00};
        ans_pend_reg <= 1'b1;
      end else if (ans_pend_reg & frame_i) begin
        ans_pend_reg <= 1'b0;
      end else if (feed_req_reg & ~ans_pend_reg) begin
        ans_msg_reg <= {`PCP_LOCAL_MONITOR_CLASS, `PCP_TYPE_FEED_ANS, 5'h00,
                        feed_value_reg};
        ans_pend_reg <= 1'b1;
      end
      // a feed request that meets a pending answer waits and is cleared only when its answer is loaded
      if (feed_rq) begin
        feed_req_reg <= 1'b1;
      end else if (~rd_done & ~ans_pend_reg) begin
        feed_req_reg <= 1'b0;
      end
      // a frame hands the pending answer to software; the set beats a clearing read
      if (ans_pend_reg & frame_i & ~rd_done) begin
        ans_valid_reg <= 1'b1;
      end else if (rd_rx) begin
        ans_valid_reg <= 1'b0;
      end
    end
  end

  // serial feed value shifted in on the first channel bit slots
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      feed_shift_reg <= 8'h00;
      feed_cnt_reg <= 4'h0;
      feed_value_reg <= 8'h00;
    end else if (ce_i) begin
      // most significant bit first; the count stops at eight so stray strobes add no bit
      if (frame_i) begin
        feed_cnt_reg <= 4'h0;
      end else if (feed_bit_strobe_i & ~nt_mode_reg & (feed_cnt_reg != `PCP_FEED_BITS)) begin
        feed_shift_reg <= {feed_shift_reg[6:0], sec_s};
        feed_cnt_reg <= feed_cnt_reg + 4'h1;
        if (feed_cnt_reg == `PCP_FEED_BITS - 4'h1) begin
          feed_value_reg <= {feed_shift_reg[6:0], sec_s};
        end
      end
    end
  end

  // command/indicate output, power pins and mode control
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      nt_mode_reg <= 1'b0;
      auto_mode_reg <= 1'b0;
      int_frames_reg <= 3'h0;
      ci_code_o <= `PCP_CI_IDLE;
      power_disable_out_o <= 1'b0;
      test_state_o <= 1'b0;
      link_drop_o <= 1'b0;
      power_off_prev_reg <= 1'b0;
      primary_status_overhead_bit_o <= 1'b0;
      secondary_status_overhead_bit_o <= 1'b0;
    end else if (ce_i) begin
      // mode bits; the peripheral port itself ignores them
      if (reg_wr_i & sel(reg_addr_i, `PCP_ADDR_CTRL)) begin
        nt_mode_reg <= reg_wdata_i[`PCP_CTRL_NT_BIT];
        auto_mode_reg <= reg_wdata_i[`PCP_CTRL_AUTO_BIT];
      end
      // a frame counts only once the code is on the output, so all four frames carry it
      if (int_s != int_prev_reg) begin
        int_frames_reg <= `PCP_INT_FRAMES;
      end else if (frame_i & (int_frames_reg != 3'h0) & (ci_code_o != `PCP_CI_IDLE)) begin
        int_frames_reg <= int_frames_reg - 3'h1;
      end
      // power-off outranks the interrupt code; the frame count still runs meanwhile
      if (lt_power_off) begin
        ci_code_o <= `PCP_CI_POWER_OFF;
      end else if (int_frames_reg != 3'h0) begin
        ci_code_o <= `PCP_CI_INTERRUPT;
      end else begin
        ci_code_o <= `PCP_CI_IDLE;
      end
      power_off_prev_reg <= lt_power_off;
      link_drop_o <= lt_power_off & ~power_off_prev_reg;
      // overhead bits are level copies of the synced pins; line mode keeps them low
      if (nt_mode_reg) begin
        primary_status_overhead_bit_o <= prim_s;
        secondary_status_overhead_bit_o <= sec_s;
        if (close_loop_cmd_i & auto_mode_reg) begin
          power_disable_out_o <= 1'b1;
        end else if (return_normal_cmd_i) begin
          power_disable_out_o <= 1'b0;
        end
        test_state_o <= 1'b0;
      end else begin
        primary_status_overhead_bit_o <= 1'b0;
        secondary_status_overhead_bit_o <= 1'b0;
        if (wr_ci & (ci_in == `PCP_CI_LINE_DISABLE)) begin
          power_disable_out_o <= 1'b1;
        end
        // soft reset leaves the disable pin alone
        // the test state follows the disable pin, so only a hardware reset or a switch to network mode ends it
        test_state_o <= lt_power_off | power_disable_out_o |
                        (wr_ci & (ci_in == `PCP_CI_LINE_DISABLE));
      end
    end
  end

  // register read port, data one cycle after the strobe
  // unmapped offsets and idle cycles read as zero
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `PCP_ADDR_CTRL: reg_rdata_o <= {30'h0000_0000, auto_mode_reg, nt_mode_reg};
          `PCP_ADDR_MON_TX: reg_rdata_o <= {31'h0000_0000, state_reg != ST_IDLE};
          `PCP_ADDR_MON_RX: reg_rdata_o <= {7'h00, ans_valid_reg, ans_msg_reg};
          `PCP_ADDR_CI: reg_rdata_o <= {28'h000_0000, ci_code_o};
          `PCP_ADDR_STATUS: reg_rdata_o <= {16'h0000, feed_value_reg, 3'h0,
                                            port_address_lines_o, test_state_o,
                                            power_disable_out_o, ans_pend_reg};
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ===== include/pcp_defs.vh
// constants for the power controller port
`ifndef PCP_DEFS_VH
`define PCP_DEFS_VH
// register byte addresses
`define PCP_ADDR_CTRL 8'h00
`define PCP_ADDR_MON_TX 8'h04
`define PCP_ADDR_MON_RX 8'h08
`define PCP_ADDR_CI 8'h0C
`define PCP_ADDR_STATUS 8'h10
// control register fields
`define PCP_CTRL_NT_BIT 0
`define PCP_CTRL_AUTO_BIT 1
// monitor message layout
`define PCP_LOCAL_MONITOR_CLASS 8'h80
`define PCP_TYPE_MSB 7
`define PCP_TYPE_LSB 5
`define PCP_DATA_MSB 4
`define PCP_DATA_LSB 2
`define PCP_ADDR_MSB 1
`define PCP_ADDR_LSB 0
`define PCP_TYPE_ANSWER 3'h0
`define PCP_TYPE_READ 3'h2
`define PCP_TYPE_WRITE 3'h3
`define PCP_TYPE_FEED_REQ 3'h4
`define PCP_TYPE_FEED_ANS 3'h5
`define PCP_RX_VALID_BIT 24
// command/indicate codes
`define PCP_CI_IDLE 4'hF
`define PCP_CI_INTERRUPT 4'h6
`define PCP_CI_POWER_OFF 4'h3
`define PCP_CI_LINE_DISABLE 4'h3
`define PCP_CI_SOFT_RESET 4'h1
// timing
`define PCP_INT_FRAMES 3'h4
`define PCP_STROBE_NS 80
`define PCP_FEED_BITS 4'h8
`endif
